// File: core/tirc_pkg.sv
// Purpose: shared constants and types of the transceiver irq/reset control
// Assumes: 50 MHz core clock, SPI frame of 8 header bits plus 16 data bits
// Notes:   addresses are 6-bit register numbers carried in the header
package tirc_pkg;

  localparam logic [5:0] ADDR_SOFT_RESET   = 6'h00;
  localparam logic [5:0] ADDR_IRQ_MASK     = 6'h05;
  localparam logic [5:0] ADDR_SEQ_CTRL     = 6'h06;
  localparam logic [5:0] ADDR_PIN_CTRL     = 6'h0c;
  localparam logic [5:0] ADDR_IRQ_STATUS   = 6'h24;
  localparam logic [5:0] ADDR_POWER_ORIGIN = 6'h25;

  // interrupt_status bit positions
  localparam int ST_DOZE    = 6;
  localparam int ST_RX      = 7;
  localparam int ST_TX      = 8;
  localparam int ST_CCA     = 9;
  localparam int ST_WAKE    = 10;
  localparam int ST_CMP_LSB = 11;
  localparam int ST_LOCK    = 15;

  // sequence control fields
  localparam int SEQ_DOZE    = 2;
  localparam int SEQ_HIB     = 3;
  localparam int SEQ_DEEP    = 4;
  localparam int SEQ_TEXIT   = 5;
  localparam int SEQ_DIS_LSB = 8;
  localparam logic [15:0] SEQ_STORE_MASK = 16'h0f30;

  // pin_output_control and power origin fields
  localparam int PIN_PUP     = 7;
  localparam int PIN_DRV_LSB = 8;
  localparam int ORIGIN_BIT  = 7;

  localparam logic [15:0] MASK_RST   = 16'h0400;
  localparam logic [15:0] PIN_RST    = 16'h0080;
  localparam logic [15:0] SEQ_RST    = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  localparam int CLK_HZ     = 50_000_000;
  localparam int PWRUP_MS   = 25;
  localparam int PWRUP_CYCLES = PWRUP_MS * (CLK_HZ / 1000);
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS   = 8;

  typedef enum logic [2:0] {
    M_OFF   = 3'b000,
    M_IDLE  = 3'b001,
    M_RX    = 3'b010,
    M_TX    = 3'b011,
    M_CCA   = 3'b100,
    M_DOZE  = 3'b101,
    M_HIBER = 3'b110
  } tirc_mode_e;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic ce_n;
  } tirc_spi_s;

  typedef struct packed {
    logic       lock_lost;
    logic       seq_done;
    logic [3:0] cmp_match;
  } tirc_evt_s;

  typedef struct packed {
    logic       out;
    logic       oe;
    logic       pullup_en;
    logic [1:0] drive;
  } tirc_irq_pin_s;

endpackage

// File: core/tirc_core.sv
// Purpose: irq status, request pin, lock-loss abort, wake and reset control
// Assumes: all pins synchronous to core_clk_i; SPI mode 0, MSB first
// Notes:   read header = bit 7 set, register number in bits 5:0
// Summary of operation
// [RULE_01] compare three/four flags set on match, cleared by status read or disable.
// [RULE_02] reading the status register clears every status bit.
// [RULE_03] request pin pulled low while any request is pending.
// [RULE_04] a status register read releases the request pin.
// [RULE_05] pull-up enable is bit 7 of pin control, set after reset.
// [RULE_06] two-bit request pin drive strength, reset value 00.
// [RULE_07] lock loss during a sequence aborts to idle and sets lock flag.
// [RULE_08] while lock flag is set, new sequences abort at once.
// [RULE_09] host reads status to clear lock flag before the next sequence.
// [RULE_10] lock-aborted receive or assessment sets no completion flag.
// [RULE_11] lock-aborted transmit still sets transmit-complete flag.
// [RULE_12] reaching idle after hardware reset sets wake flag; mask on by reset.
// [RULE_13] wake input ending a low-power mode sets wake flag.
// [RULE_14] host sets wake mask before entering hibernate or doze.
// [RULE_15] wake input always ends doze, even with timer exit enabled.
// [RULE_16] compare two match ends timer doze and sets doze flag; deep doze excluded.
// [RULE_17] held off during hardware reset; idle within 25 ms after release.
// [RULE_18] write to register 00 resets logic and registers and forces idle.
// [RULE_19] software reset held until chip select returns high.
// [RULE_20] reset indicator cleared by any reset, kept across low-power modes.
// [RULE_21] first read of register 25 after reset sets the indicator.
// [RULE_22] wake flag is status bit 10, its mask set out of reset.
// [RULE_23] no compare two flag while compare two is used for doze exit.
// [RULE_24] request pending is OR of each flag ANDed with its mask.
// [RULE_25] flags set regardless of mask.
`timescale 1ns/1ps
`default_nettype none
module tirc_core #(
  parameter int unsigned PWRUP_CYCLES = tirc_pkg::PWRUP_CYCLES
) (
  // clock, reset, enable
  input  wire logic                    core_clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    en_i,
  // spi
  input  wire tirc_pkg::tirc_spi_s     spi_i,
  output logic                         miso_o,
  // radio events and wake pin
  input  wire tirc_pkg::tirc_evt_s     evt_i,
  input  wire logic                    attn_n_i,
  // request pin and mode
  output tirc_pkg::tirc_irq_pin_s      irq_o,
  output tirc_pkg::tirc_mode_e         mode_o
);
  import tirc_pkg::*;

  localparam int CW = (PWRUP_CYCLES > 1) ? $clog2(PWRUP_CYCLES) : 1;
  localparam logic [CW-1:0] PWR_LAST = CW'(PWRUP_CYCLES - 1);

  tirc_mode_e  mode_q, mode_d;
  logic [15:0] status_q, mask_q, pin_q, seq_q, set_v, clr_v, rd_val;
  logic [15:0] sh_q, out_q, wr_data;
  logic [7:0]  hdr_q, hdr_next;
  logic [4:0]  bit_cnt_q;
  logic [CW-1:0] pwr_cnt_q;
  logic        sclk_q, srst_q, rst_ind_q;
  logic        sclk_rise, sclk_fall, hdr_done, rd_hdr, wr_done;
  logic        status_rd, origin_rd, seq_wr, timer_doze;

  function automatic logic hit(input logic stb, input logic [5:0] a, input logic [5:0] b);
    return stb && (a == b);
  endfunction

  // spi framing: edges seen against the previous sample of sclk
  assign sclk_rise = spi_i.sclk && !sclk_q && !spi_i.ce_n;
  assign sclk_fall = !spi_i.sclk && sclk_q && !spi_i.ce_n;
  assign hdr_next  = {sh_q[6:0], spi_i.mosi};
  assign wr_data   = {sh_q[14:0], spi_i.mosi};
  assign hdr_done  = sclk_rise && (bit_cnt_q == 5'(HDR_BITS - 1));
  assign rd_hdr    = hdr_done && hdr_next[7];
  assign wr_done   = sclk_rise && (bit_cnt_q == 5'(FRAME_BITS - 1)) && !hdr_q[7];
  assign status_rd = hit(rd_hdr, hdr_next[5:0], ADDR_IRQ_STATUS);
  assign origin_rd = hit(rd_hdr, hdr_next[5:0], ADDR_POWER_ORIGIN);
  assign seq_wr    = hit(wr_done, hdr_q[5:0], ADDR_SEQ_CTRL);
  // compare two is reserved for doze exit only while this holds
  assign timer_doze = (mode_q == M_DOZE) && seq_q[SEQ_TEXIT] && !seq_q[SEQ_DEEP];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q    <= 1'b0;
      bit_cnt_q <= 5'h00;
      sh_q      <= 16'h0000;
      hdr_q     <= 8'h00;
    end else if (en_i) begin
      sclk_q <= spi_i.sclk;
      if (spi_i.ce_n) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        sh_q      <= wr_data;
        bit_cnt_q <= wr_done || bit_cnt_q == 5'(FRAME_BITS - 1) ? 5'h00 : bit_cnt_q + 5'h01;
        if (hdr_done) begin
          hdr_q <= hdr_next;
        end
      end
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    case (hdr_next[5:0])
      ADDR_IRQ_MASK:     rd_val = mask_q;
      ADDR_SEQ_CTRL:     rd_val = seq_q;
      ADDR_PIN_CTRL:     rd_val = pin_q;
      ADDR_IRQ_STATUS:   rd_val = status_q;
      ADDR_POWER_ORIGIN: rd_val[ORIGIN_BIT] = rst_ind_q;
      default:           rd_val = 16'h0000;
    endcase
  end

  // read data is loaded after the header and shifted on falling edges, so the
  // first data bit is already stable for the host's next rising edge
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_q <= 16'h0000;
    end else if (en_i) begin
      if (hdr_done) begin
        out_q <= rd_hdr ? rd_val : 16'h0000;
      end else if (sclk_fall && bit_cnt_q > 5'(HDR_BITS)) begin
        out_q <= {out_q[14:0], 1'b0};
      end
    end
  end
  assign miso_o = out_q[15];

  // software reset: starts at the end of the write, lasts until chip select rises
  // holding reset to the end of the frame keeps the remaining sclk edges from landing anywhere
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      srst_q <= 1'b0;
    end else if (en_i) begin
      if (spi_i.ce_n) begin
        srst_q <= 1'b0; // [RULE_19]
      end else if (hit(wr_done, hdr_q[5:0], ADDR_SOFT_RESET)) begin
        srst_q <= 1'b1; // [RULE_18]
      end
    end
  end

  // transceiver mode and status events
  always_comb begin
    mode_d = mode_q;
    set_v  = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      set_v[ST_CMP_LSB + i] = evt_i.cmp_match[i] && !seq_q[SEQ_DIS_LSB + i]; // [RULE_01] [RULE_25]
    end
    if (timer_doze) begin
      set_v[ST_CMP_LSB + 1] = 1'b0; // [RULE_23]
    end
    unique case (mode_q)
      M_OFF: begin
        if (pwr_cnt_q == PWR_LAST) begin
          mode_d         = M_IDLE; // [RULE_17]
          set_v[ST_WAKE] = 1'b1; // [RULE_12]
        end
      end
      M_IDLE: begin
        if (seq_wr) begin
          if (wr_data[1:0] != 2'b00) begin
            // a pending lock loss swallows the start: the sequence never runs
            if (!status_q[ST_LOCK]) begin // [RULE_08] [RULE_09]
              unique case (wr_data[1:0])
                2'b01:   mode_d = M_RX;
                2'b10:   mode_d = M_TX;
                default: mode_d = M_CCA;
              endcase
            end
          end else if (wr_data[SEQ_DOZE]) begin
            mode_d = M_DOZE;
          end else if (wr_data[SEQ_HIB]) begin
            mode_d = M_HIBER;
          end
        end
      end
      M_RX, M_TX, M_CCA: begin
        if (evt_i.lock_lost) begin
          mode_d         = M_IDLE; // [RULE_07]
          set_v[ST_LOCK] = 1'b1;
          set_v[ST_TX]   = (mode_q == M_TX); // [RULE_11] [RULE_10]
        end else if (evt_i.seq_done) begin
          mode_d          = M_IDLE;
          set_v[ST_RX]    = (mode_q == M_RX);
          set_v[ST_TX]    = (mode_q == M_TX);
          set_v[ST_CCA]   = (mode_q == M_CCA);
        end
      end
      M_DOZE: begin
        if (!attn_n_i) begin
          mode_d         = M_IDLE; // [RULE_15]
          set_v[ST_WAKE] = 1'b1; // [RULE_13]
        end else if (timer_doze && evt_i.cmp_match[1]) begin
          mode_d         = M_IDLE; // [RULE_16]
          set_v[ST_DOZE] = 1'b1;
        end
      end
      M_HIBER: begin
        if (!attn_n_i) begin
          mode_d         = M_IDLE;
          set_v[ST_WAKE] = 1'b1; // [RULE_13]
        end
      end
      default: mode_d = M_IDLE;
    endcase
  end

  // power-up wait counts enabled cycles only, so a held enable stretches it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q    <= M_OFF;
      pwr_cnt_q <= '0;
    end else if (en_i) begin
      mode_q    <= srst_q ? M_IDLE : mode_d; // [RULE_18]
      pwr_cnt_q <= (mode_q == M_OFF) ? pwr_cnt_q + CW'(1) : '0;
    end
  end

  // set wins over either clear
  always_comb begin
    clr_v = 16'h0000;
    clr_v[ST_CMP_LSB +: 4] = seq_q[SEQ_DIS_LSB +: 4]; // [RULE_01]
    if (status_rd) begin
      clr_v = 16'hffff; // [RULE_02]
    end
  end

  // a software reset also drops every pending request with the flags
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= STATUS_RST;
    end else if (en_i) begin
      status_q <= srst_q ? STATUS_RST : (status_q & ~clr_v) | set_v;
    end
  end

  // software-written registers
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_q <= MASK_RST; // [RULE_22]
      pin_q  <= PIN_RST; // [RULE_05] [RULE_06]
      seq_q  <= SEQ_RST;
    end else if (en_i) begin
      if (srst_q) begin
        mask_q <= MASK_RST;
        pin_q  <= PIN_RST;
        seq_q  <= SEQ_RST;
      end else begin
        if (hit(wr_done, hdr_q[5:0], ADDR_IRQ_MASK)) begin
          mask_q <= wr_data;
        end
        if (hit(wr_done, hdr_q[5:0], ADDR_PIN_CTRL)) begin
          pin_q <= wr_data;
        end
        if (seq_wr) begin
          seq_q <= wr_data & SEQ_STORE_MASK;
        end
      end
    end
  end

  // reset indicator: only a reset clears it, low-power modes leave it alone
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_ind_q <= 1'b0; // [RULE_20]
    end else if (en_i) begin
      if (srst_q) begin
        rst_ind_q <= 1'b0; // [RULE_20]
      end else if (origin_rd) begin
        rst_ind_q <= 1'b1; // [RULE_21]
      end
    end
  end

  // open drain: only ever drives low
  assign irq_o = '{out:       1'b0,
                   oe:        |(status_q & mask_q), // [RULE_03] [RULE_04] [RULE_24]
                   pullup_en: pin_q[PIN_PUP], // [RULE_05]
                   drive:     pin_q[PIN_DRV_LSB +: 2]}; // [RULE_06]
  assign mode_o          = mode_q;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence lock_hit;
    en_i && !srst_q && evt_i.lock_lost && (mode_q inside {M_RX, M_TX, M_CCA});
  endsequence
  sequence idle_locked;
    mode_q == M_IDLE && status_q[ST_LOCK];
  endsequence

  lock_abort_a: assert property (lock_hit |=> idle_locked) // [RULE_07]
    else $error("lock loss did not abort to idle");
  rx_no_flag_a: assert property ( // [RULE_10]
      lock_hit |=> !$rose(status_q[ST_RX]) && !$rose(status_q[ST_CCA]))
    else $error("aborted receive or assessment set a completion flag");
  tx_abort_flag_a: assert property (lock_hit and mode_q == M_TX |=> status_q[ST_TX]) // [RULE_11]
    else $error("aborted transmit lost its flag");
  lock_block_a: assert property ( // [RULE_08]
      idle_locked and (en_i && !srst_q && !status_rd) |=> !(mode_q inside {M_RX, M_TX, M_CCA}))
    else $error("sequence started with lock flag set");
  read_clear_a: assert property (en_i && !srst_q && status_rd && set_v == 16'h0000
                                 |=> status_q == 16'h0000 && !irq_o.oe) // [RULE_04]
    else $error("status read did not clear and release");
  cmp_disable_a: assert property ( // [RULE_01]
      en_i && seq_q[SEQ_DIS_LSB + 2] |=> !status_q[ST_CMP_LSB + 2])
    else $error("disabled compare three flag set");
  wake_flag_a: assert property (en_i && !srst_q && !attn_n_i && (mode_q inside {M_DOZE, M_HIBER})
                                |=> mode_q == M_IDLE && status_q[ST_WAKE]) // [RULE_13]
    else $error("wake input did not end low-power mode");
  doze_timer_a: assert property ( // [RULE_16] [RULE_23]
      en_i && !srst_q && attn_n_i && timer_doze && evt_i.cmp_match[1]
      |=> status_q[ST_DOZE] && !$rose(status_q[ST_CMP_LSB + 1]))
    else $error("timer doze exit flags wrong");
  powerup_a: assert property (en_i && !srst_q && mode_q == M_OFF && pwr_cnt_q == PWR_LAST
                              |=> mode_q == M_IDLE && status_q[ST_WAKE] && irq_o.oe) // [RULE_12]
    else $error("power-up did not wake with request");
  soft_release_a: assert property ( // [RULE_19]
      en_i && srst_q && spi_i.ce_n |=> !srst_q ##1 mode_q == M_IDLE)
    else $error("software reset not released on chip select");
  origin_set_a: assert property (en_i && !srst_q && origin_rd |=> rst_ind_q) // [RULE_21]
    else $error("reset indicator not set by read");

  // a low enable must freeze the whole state, not only what reaches the pins
  state_freeze_a: assert property (!en_i |=> $stable(mode_q) && $stable(status_q) && $stable(srst_q))
    else $error("state moved while enable was low");
  off_hold_a: assert property ( // [RULE_17]
      en_i && !srst_q && mode_q == M_OFF && pwr_cnt_q != PWR_LAST |=> mode_q == M_OFF)
    else $error("left power-down before the wait ran out");
  soft_clear_a: assert property ( // [RULE_18] [RULE_20]
      en_i && srst_q |=> mode_q == M_IDLE && status_q == STATUS_RST && mask_q == MASK_RST
                         && pin_q == PIN_RST && !rst_ind_q)
    else $error("software reset left state behind");
  ind_kept_a: assert property ( // [RULE_20]
      en_i && !srst_q && !origin_rd |=> $stable(rst_ind_q))
    else $error("reset indicator changed without a reset or read");
  flag_unmasked_a: assert property ( // [RULE_25]
      en_i && !srst_q && evt_i.cmp_match[3] && !seq_q[SEQ_DIS_LSB + 3]
      |=> status_q[ST_CMP_LSB + 3])
    else $error("compare four event lost its flag");

endmodule
`default_nettype wire

// File: testbench/tirc_host_model.sv
// Purpose: host microcontroller model that runs spi frames against the block
// Assumes: mode 0, msb first, every sclk phase held at least 3 core cycles
// Notes:   the request line has an external pull-up, so a released pin reads 1
`timescale 1ns/1ps
`default_nettype none
module tirc_host_model
  import tirc_pkg::*;
(
  // clock
  input  wire logic           core_clk_i,
  // spi and request line
  output var  tirc_spi_s      spi_o,
  input  wire logic           miso_i,
  input  wire logic           irq_oe_i,
  output logic                irq_n_o,
  // read results
  output logic                rd_valid_o,
  output logic [15:0]         rd_data_o
);
  // open drain: only the enable matters, the pull-up gives the high level
  assign irq_n_o = irq_oe_i ? 1'b0 : 1'b1;

  initial begin
    spi_o      = '{sclk: 1'b0, mosi: 1'b0, ce_n: 1'b1};
    rd_valid_o = 1'b0;
    rd_data_o  = '0;
  end

  // one whole frame: 8 header bits then one 16-bit word
  task automatic xfer(input logic [7:0] hdr, input logic [15:0] wd);
    logic [23:0] f;
    logic [15:0] r;
    f = {hdr, wd};
    r = '0;
    @(posedge core_clk_i);
    spi_o.ce_n <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk_i);
      spi_o.sclk <= 1'b0;
      spi_o.mosi <= f[23-i];
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      if (i >= 8) r[23-i] = miso_i;
      @(posedge core_clk_i);
      spi_o.sclk <= 1'b1;
      repeat (2) @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
    spi_o.sclk <= 1'b0;
    // a released data line must not keep showing its last level
    spi_o.mosi <= ~f[0];
    repeat (2) @(posedge core_clk_i);
    spi_o.ce_n <= 1'b1;
    rd_data_o  <= r;
    rd_valid_o <= hdr[7];
    @(posedge core_clk_i);
    rd_valid_o <= 1'b0;
    @(negedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the irq, wake and reset control block
// Assumes: short power-up count of 16 cycles, host model runs all frames
// Notes:   read results are matched in order against an expectation queue
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tirc_pkg::*;
  localparam int unsigned PWR = 16;
  logic          core_clk_i;
  logic          arst_n_i;
  logic          en_i;
  logic          attn_n_i;
  logic          miso_o;
  logic          irq_n;
  logic          rd_valid;
  logic [15:0]   rd_data;
  logic [31:0]   seed;
  logic [15:0]   exp_q[$];
  tirc_spi_s     spi_i;
  tirc_evt_s     evt_i;
  tirc_irq_pin_s irq_o;
  tirc_mode_e    mode_o;
  int            fail_count;
  int            cmp_count;

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  tirc_core #(.PWRUP_CYCLES(PWR)) u_tirc_core (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .en_i(en_i), .spi_i(spi_i),
    .miso_o(miso_o), .evt_i(evt_i), .attn_n_i(attn_n_i), .irq_o(irq_o), .mode_o(mode_o));

  tirc_host_model u_tirc_host_model (
    .core_clk_i(core_clk_i), .spi_o(spi_i), .miso_i(miso_o), .irq_oe_i(irq_o.oe),
    .irq_n_o(irq_n), .rd_valid_o(rd_valid), .rd_data_o(rd_data));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_tirc_host_model.xfer({2'b10, a}, 16'h0000);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    u_tirc_host_model.xfer({2'b00, a}, d);
  endtask

  task automatic evt(input logic lk, input logic dn, input logic [3:0] cm);
    @(posedge core_clk_i);
    evt_i <= '{lock_lost: lk, seq_done: dn, cmp_match: cm};
    @(posedge core_clk_i);
    evt_i <= '0;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  task automatic wake;
    @(posedge core_clk_i);
    attn_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    attn_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  // reads come back in request order, so the oldest note is the one to compare
  always @(posedge core_clk_i) begin
    if (rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
  end

  initial begin
    #400_000;
    fail_count++;
    final_report();
  end

  initial begin
    arst_n_i = 1'b0;
    en_i     = 1'b1;
    attn_n_i = 1'b1;
    evt_i    = '0;
    seed     = 32'h397f;
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check(mode_o, M_OFF);
    check(irq_o, 5'b00100);
    @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (PWR / 2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check(mode_o, M_OFF);
    for (int n = 0; n < 100 && mode_o !== M_IDLE; n++) @(negedge core_clk_i);
    check(mode_o, M_IDLE);
    check(irq_n, 1'b0);
    rd(ADDR_IRQ_STATUS, 16'h0400);
    check(irq_n, 1'b1);
    rd(ADDR_POWER_ORIGIN, 16'h0000);
    rd(ADDR_POWER_ORIGIN, 16'h0080);
    rd(ADDR_PIN_CTRL, PIN_RST);
    rd(6'h3f, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      wr(ADDR_PIN_CTRL, seed[15:0]);
      check(irq_o.pullup_en, seed[7]);
      check(irq_o.drive, seed[9:8]);
      rd(ADDR_PIN_CTRL, seed[15:0]);
    end
    wr(ADDR_IRQ_MASK, 16'h0000);
    evt(1'b0, 1'b0, 4'b1100);
    check(irq_n, 1'b1);
    rd(ADDR_IRQ_STATUS, 16'h6000);
    wr(ADDR_IRQ_MASK, 16'h2000);
    evt(1'b0, 1'b0, 4'b0100);
    check(irq_n, 1'b0);
    wr(ADDR_SEQ_CTRL, 16'h0400);
    check(irq_n, 1'b1);
    wr(ADDR_SEQ_CTRL, 16'h0000);
    rd(ADDR_IRQ_STATUS, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h8000);
    wr(ADDR_SEQ_CTRL, 16'h0002);
    check(mode_o, M_TX);
    evt(1'b1, 1'b0, 4'b0000);
    check(mode_o, M_IDLE);
    check(irq_n, 1'b0);
    wr(ADDR_SEQ_CTRL, 16'h0003);
    check(mode_o, M_IDLE);
    // status is read to clear the lock flag before the next sequence
    rd(ADDR_IRQ_STATUS, 16'h8100);
    wr(ADDR_SEQ_CTRL, 16'h0001);
    check(mode_o, M_RX);
    evt(1'b1, 1'b0, 4'b0000);
    rd(ADDR_IRQ_STATUS, 16'h8000);
    wr(ADDR_SEQ_CTRL, 16'h0003);
    check(mode_o, M_CCA);
    evt(1'b0, 1'b1, 4'b0000);
    rd(ADDR_IRQ_STATUS, 16'h0200);
    // wake and doze masks go in before any low-power entry
    wr(ADDR_IRQ_MASK, 16'h0440);
    wr(ADDR_SEQ_CTRL, 16'h0024);
    check(mode_o, M_DOZE);
    wake();
    check(mode_o, M_IDLE);
    check(irq_n, 1'b0);
    rd(ADDR_IRQ_STATUS, 16'h0400);
    wr(ADDR_SEQ_CTRL, 16'h0024);
    evt(1'b0, 1'b0, 4'b0010);
    check(mode_o, M_IDLE);
    rd(ADDR_IRQ_STATUS, 16'h0040);
    wr(ADDR_SEQ_CTRL, 16'h0034);
    evt(1'b0, 1'b0, 4'b0010);
    check(mode_o, M_DOZE);
    wake();
    wr(ADDR_SEQ_CTRL, 16'h0008);
    check(mode_o, M_HIBER);
    @(posedge core_clk_i);
    en_i <= 1'b0;
    wake();
    check(mode_o, M_HIBER);
    @(posedge core_clk_i);
    en_i <= 1'b1;
    wake();
    check(mode_o, M_IDLE);
    rd(ADDR_POWER_ORIGIN, 16'h0080);
    wr(ADDR_SEQ_CTRL, 16'h0002);
    wr(ADDR_SOFT_RESET, 16'h0000);
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check(mode_o, M_IDLE);
    check(irq_n, 1'b1);
    rd(ADDR_PIN_CTRL, PIN_RST);
    rd(ADDR_POWER_ORIGIN, 16'h0000);
    rd(ADDR_IRQ_MASK, MASK_RST);
    repeat (5) @(posedge core_clk_i);
    final_report();
  end
endmodule
`default_nettype wire
